// file: src/lpirq_pkg.sv
// constants, types and priority arbitration for the low-power and interrupt-priority block
package lpirq_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] LPIRQ_IDX_PWR_CTRL = 8'h87;
	localparam logic [7:0] LPIRQ_IDX_PRIO_HI  = 8'hB7;
	localparam logic [7:0] LPIRQ_IDX_PRIO_LO  = 8'hB8;
	localparam logic [7:0] LPIRQ_IDX_STATUS   = 8'hC0;
	localparam logic [7:0] LPIRQ_IDX_BITSET   = 8'hC1;

	// power control field positions
	localparam int LPIRQ_PWR_IDLE  = 0;
	localparam int LPIRQ_PWR_PDOWN = 1;
	localparam int LPIRQ_PWR_UFA   = 2;
	localparam int LPIRQ_PWR_UFB   = 3;

	// source positions in both priority registers (also poll order)
	localparam int LPIRQ_SRC_EXT0 = 0;
	localparam int LPIRQ_SRC_EXT1 = 2;
	localparam int LPIRQ_NSRC     = 5;

	// single-bit access register fields
	localparam int LPIRQ_BIT_VAL  = 3;

	// reset values
	localparam logic [4:0] LPIRQ_PRIO_RST = 5'h00;
	localparam logic [1:0] LPIRQ_UF_RST   = 2'h0;

	typedef enum logic [3:0] {
		LPS_RUN   = 4'h1,
		LPS_IDLE  = 4'h2,
		LPS_PDOWN = 4'h4,
		LPS_WAKE  = 4'h8
	} lpirq_state_t;

	// {valid, level[1:0], source[2:0]}; strict compare keeps lower index on ties
	function automatic logic [5:0] lpirq_pick(input logic [4:0] req, input logic [4:0] hi, input logic [4:0] lo);
		logic       found;
		logic [1:0] lvl;
		logic [2:0] src;
		found = 1'b0;
		lvl   = 2'h0;
		src   = 3'h0;
		for (int i = 0; i < LPIRQ_NSRC; i++) begin
			if (req[i] && (!found || {hi[i], lo[i]} > lvl)) begin
				found = 1'b1;
				lvl   = {hi[i], lo[i]};
				src   = 3'(i);
			end
		end
		return {found, lvl, src};
	endfunction

endpackage

// file: src/lpirq_top.sv
// low-power mode control with interrupt priority registers on an avalon-mm slave
`timescale 1ns/1ps
module lpirq_top
	import lpirq_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RESET_I,
	// avalon-mm slave
	input  wire logic [9:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// processor core side
	input  wire logic        INSTR_DONE_I,
	input  wire logic        CORE_ALE_I,
	input  wire logic        CORE_PROG_STROBE_I,
	input  wire logic [4:0]  IRQ_REQ_I,
	input  wire logic [4:0]  IRQ_EN_I,
	input  wire logic        IRQ_GLOBAL_EN_I,
	// external interrupt pins, active low
	input  wire logic        EXT_IRQ_PIN_A_N_I,
	input  wire logic        EXT_IRQ_PIN_B_N_I,
	// clock gating and pin control
	output logic             CORE_CLK_EN_O,
	output logic             PERIPH_CLK_EN_O,
	output logic             OSC_EN_O,
	output logic             ALE_O,
	output logic             PROGRAM_STORE_STROBE_O,
	output logic             PORT_HOLD_O,
	output logic             PORT0_FLOAT_O,
	output logic             PORT2_ADDR_O,
	// interrupt selection
	output logic             IRQ_VALID_O,
	output logic      [2:0]  IRQ_SRC_O,
	output logic      [1:0]  IRQ_LEVEL_O,
	output logic             WAKE_VECTOR_O
);

	typedef struct packed {
		lpirq_state_t state;
		logic [4:0]   prio_high;
		logic [4:0]   prio_low;
		logic         idle_request_bit;
		logic         powerdown_request_bit;
		logic         user_flag_a;
		logic         user_flag_b;
		logic         wreq;
		logic [7:0]   rdata;
		logic         ale;
		logic         pstrobe;
		logic         core_clk;
		logic         periph_clk;
		logic         osc;
		logic         hold;
		logic         p0_float;
		logic         p2_addr;
		logic         irq_valid;
		logic [2:0]   irq_src;
		logic [1:0]   irq_lvl;
		logic         wake_vec;
		logic [1:0]   wake_mask;
	} lpirq_st_t;

	lpirq_st_t   st_q;
	lpirq_st_t   st_d;
	logic        bus_req;
	logic        bus_commit;
	logic [7:0]  idx;
	logic [4:0]  req_en;
	logic [5:0]  pick_n;
	logic [5:0]  pick_w;
	logic [1:0]  pins_low;
	logic [1:0]  pins_rel;
	logic [4:0]  wake_req;

	assign bus_req    = AVS_READ_I || AVS_WRITE_I;
	assign bus_commit = AVS_WRITE_I && !st_q.wreq && AVS_BYTEENABLE_I[0];
	assign idx        = AVS_ADDRESS_I[9:2];
	assign req_en     = IRQ_REQ_I & IRQ_EN_I & {5{IRQ_GLOBAL_EN_I}};
	assign pick_n     = lpirq_pick(req_en, st_q.prio_high, st_q.prio_low);

	// only the two external pins can wake from power-down
	assign pins_low = {~EXT_IRQ_PIN_B_N_I & IRQ_EN_I[LPIRQ_SRC_EXT1],
		~EXT_IRQ_PIN_A_N_I & IRQ_EN_I[LPIRQ_SRC_EXT0]} & {2{IRQ_GLOBAL_EN_I}};
	assign pins_rel = st_q.wake_mask & {EXT_IRQ_PIN_B_N_I, EXT_IRQ_PIN_A_N_I};

	always_comb begin
		wake_req = '0;
		wake_req[LPIRQ_SRC_EXT0] = st_q.wake_mask[0];
		wake_req[LPIRQ_SRC_EXT1] = st_q.wake_mask[1];
	end

	// among all enabled pins held low, the higher priority one is served
	assign pick_w = lpirq_pick(wake_req, st_q.prio_high, st_q.prio_low);

	always_comb begin
		st_d          = st_q;
		st_d.wreq     = 1'b1;
		st_d.wake_vec = 1'b0;

		// first request cycle: capture read data, drop waitrequest next edge
		if (bus_req && st_q.wreq) begin
			st_d.wreq  = 1'b0;
			st_d.rdata = 8'h00;
			if (idx == LPIRQ_IDX_PWR_CTRL) begin
				st_d.rdata = {4'h0, st_q.user_flag_b, st_q.user_flag_a,
					st_q.powerdown_request_bit, st_q.idle_request_bit};
			end else if (idx == LPIRQ_IDX_PRIO_HI) begin
				st_d.rdata = {3'h0, st_q.prio_high};
			end else if (idx == LPIRQ_IDX_PRIO_LO) begin
				st_d.rdata = {3'h0, st_q.prio_low};
			end else if (idx == LPIRQ_IDX_STATUS) begin
				st_d.rdata = {pick_n[5], pick_n[4:3], pick_n[2:0],
					st_q.state == LPS_PDOWN || st_q.state == LPS_WAKE, st_q.state == LPS_IDLE};
			end
		end

		// mode sequencing; leaving idle clears the idle request bit, leaving power-down clears both mode request bits in hardware
		case (st_q.state)
			LPS_RUN: begin
				if (INSTR_DONE_I && st_q.powerdown_request_bit) begin
					st_d.state = LPS_PDOWN;
				end else if (INSTR_DONE_I && st_q.idle_request_bit) begin
					st_d.state = LPS_IDLE;
				end
			end
			LPS_IDLE: begin
				if (pick_n[5]) begin
					st_d.state            = LPS_RUN;
					st_d.idle_request_bit = 1'b0;
					st_d.wake_vec         = 1'b1;
				end
			end
			LPS_PDOWN: begin
				if (|pins_low) begin
					st_d.state     = LPS_WAKE;
					st_d.wake_mask = pins_low;
				end
			end
			LPS_WAKE: begin
				// oscillator runs; the waker holds the pin until it has settled
				if (|pins_rel) begin
					st_d.state                 = LPS_RUN;
					st_d.idle_request_bit      = 1'b0;
					st_d.powerdown_request_bit = 1'b0;
					st_d.wake_vec              = 1'b1;
					st_d.wake_mask             = 2'h0;
				end else begin
					st_d.wake_mask = st_q.wake_mask | pins_low;
				end
			end
			default: begin
				st_d.state = LPS_RUN;
			end
		endcase

		// a write in the same cycle as a hardware clear wins
		if (bus_commit) begin
			if (idx == LPIRQ_IDX_PWR_CTRL) begin
				st_d.idle_request_bit      = AVS_WRITEDATA_I[LPIRQ_PWR_IDLE];
				st_d.powerdown_request_bit = AVS_WRITEDATA_I[LPIRQ_PWR_PDOWN];
				st_d.user_flag_a           = AVS_WRITEDATA_I[LPIRQ_PWR_UFA];
				st_d.user_flag_b           = AVS_WRITEDATA_I[LPIRQ_PWR_UFB];
			end else if (idx == LPIRQ_IDX_PRIO_HI) begin
				st_d.prio_high = AVS_WRITEDATA_I[4:0];
			end else if (idx == LPIRQ_IDX_PRIO_LO) begin
				st_d.prio_low = AVS_WRITEDATA_I[4:0];
			end else if (idx == LPIRQ_IDX_BITSET) begin
				// single-bit access reaches the low bits only
				if (AVS_WRITEDATA_I[2:0] < 3'(LPIRQ_NSRC)) begin
					st_d.prio_low[AVS_WRITEDATA_I[2:0]] = AVS_WRITEDATA_I[LPIRQ_BIT_VAL];
				end
			end
		end

		// pin and clock controls follow the next state so they line up with it
		st_d.core_clk   = st_d.state == LPS_RUN;
		st_d.periph_clk = st_d.state != LPS_PDOWN;
		st_d.osc        = st_d.state != LPS_PDOWN;
		st_d.hold       = st_d.state != LPS_RUN;
		st_d.p0_float   = st_d.state != LPS_RUN;
		st_d.p2_addr    = st_d.state == LPS_IDLE;
		if (st_d.state == LPS_RUN) begin
			st_d.ale     = CORE_ALE_I;
			st_d.pstrobe = CORE_PROG_STROBE_I;
		end else begin
			st_d.ale     = st_d.state == LPS_IDLE;
			st_d.pstrobe = st_d.state == LPS_IDLE;
		end

		st_d.irq_valid = (st_d.state == LPS_RUN) && (pick_n[5] || st_d.wake_vec);
		if (st_q.state == LPS_WAKE) begin
			st_d.irq_src = pick_w[2:0];
			st_d.irq_lvl = pick_w[4:3];
		end else begin
			st_d.irq_src = pick_n[2:0];
			st_d.irq_lvl = pick_n[4:3];
		end
	end

	// reset puts every register back; leaving power-down by pin does not
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			st_q                       <= '0;
			st_q.state                 <= LPS_RUN;
			st_q.prio_high             <= LPIRQ_PRIO_RST;
			st_q.prio_low              <= LPIRQ_PRIO_RST;
			st_q.powerdown_request_bit <= 1'b0;
			{st_q.user_flag_b, st_q.user_flag_a} <= LPIRQ_UF_RST;
			st_q.wreq                  <= 1'b1;
			st_q.core_clk              <= 1'b1;
			st_q.periph_clk            <= 1'b1;
			st_q.osc                   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign AVS_READDATA_O         = {24'h000000, st_q.rdata};
	assign AVS_WAITREQUEST_O      = st_q.wreq;
	assign CORE_CLK_EN_O          = st_q.core_clk;
	assign PERIPH_CLK_EN_O        = st_q.periph_clk;
	assign OSC_EN_O               = st_q.osc;
	assign ALE_O                  = st_q.ale;
	assign PROGRAM_STORE_STROBE_O = st_q.pstrobe;
	assign PORT_HOLD_O            = st_q.hold;
	assign PORT0_FLOAT_O          = st_q.p0_float;
	assign PORT2_ADDR_O           = st_q.p2_addr;
	assign IRQ_VALID_O            = st_q.irq_valid;
	assign IRQ_SRC_O              = st_q.irq_src;
	assign IRQ_LEVEL_O            = st_q.irq_lvl;
	assign WAKE_VECTOR_O          = st_q.wake_vec;

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_pdown_pin_low;
		st_q.state == LPS_PDOWN && |pins_low;
	endsequence

	sequence s_wake_hold;
		st_q.state == LPS_WAKE && OSC_EN_O && !CORE_CLK_EN_O;
	endsequence

	chk_low_bits_write: assert property (
		bus_commit && idx == LPIRQ_IDX_PRIO_LO |=> st_q.prio_low == $past(AVS_WRITEDATA_I[4:0]))
		else $error("low priority bits not written");

	chk_high_bits_write: assert property (
		bus_commit && idx == LPIRQ_IDX_PRIO_HI |=> st_q.prio_high == $past(AVS_WRITEDATA_I[4:0]))
		else $error("high priority bits not written");

	chk_high_no_bitop: assert property (
		bus_commit && idx == LPIRQ_IDX_BITSET |=> $stable(st_q.prio_high))
		else $error("single-bit access changed high bits");

	chk_idle_entry: assert property (
		st_q.state == LPS_RUN && st_q.idle_request_bit && !st_q.powerdown_request_bit && INSTR_DONE_I
		|=> st_q.state == LPS_IDLE && !CORE_CLK_EN_O && PERIPH_CLK_EN_O)
		else $error("idle not entered after instruction");

	chk_idle_pins: assert property (
		st_q.state == LPS_IDLE |-> ALE_O && PROGRAM_STORE_STROBE_O && PORT_HOLD_O && PORT2_ADDR_O)
		else $error("idle pin states wrong");

	chk_pdown_pins: assert property (
		st_q.state == LPS_PDOWN |-> !OSC_EN_O && !ALE_O && !PROGRAM_STORE_STROBE_O && !PORT2_ADDR_O)
		else $error("power-down pin states wrong");

	chk_idle_wake: assert property (
		st_q.state == LPS_IDLE && pick_n[5]
		|=> st_q.state == LPS_RUN && WAKE_VECTOR_O && !st_q.idle_request_bit ##1 !WAKE_VECTOR_O)
		else $error("idle not ended by interrupt");

	chk_pdown_restart: assert property (
		s_pdown_pin_low |=> s_wake_hold)
		else $error("oscillator not restarted by pin");

	chk_wake_waits: assert property (
		st_q.state == LPS_WAKE && !(|pins_rel) |=> st_q.state == LPS_WAKE && !CORE_CLK_EN_O)
		else $error("power-down exit before release");

	chk_both_clear: assert property (
		st_q.state == LPS_WAKE && |pins_rel && !bus_commit
		|=> st_q.state == LPS_RUN && !st_q.idle_request_bit && !st_q.powerdown_request_bit)
		else $error("mode bits not cleared at exit");

	chk_wait_one: assert property (
		bus_req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("waitrequest held more than one cycle");

	// bus answer timing, read path and single-bit write
	sequence s_bus_first;
		bus_req && AVS_WAITREQUEST_O;
	endsequence

	chk_wait_idle: assert property (
		!(bus_req && AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
		else $error("waitrequest not back high after answer");

	chk_read_low: assert property (
		s_bus_first && idx == LPIRQ_IDX_PRIO_LO |=> AVS_READDATA_O == {27'h0, $past(st_q.prio_low)})
		else $error("low priority bits read wrong");

	chk_read_high: assert property (
		s_bus_first && idx == LPIRQ_IDX_PRIO_HI |=> AVS_READDATA_O == {27'h0, $past(st_q.prio_high)})
		else $error("high priority bits read wrong");

	chk_read_unmapped: assert property (
		s_bus_first && idx > LPIRQ_IDX_BITSET |=> AVS_READDATA_O == 32'h00000000)
		else $error("unmapped index read not zero");

	chk_bit_write: assert property (
		bus_commit && idx == LPIRQ_IDX_BITSET && AVS_WRITEDATA_I[2:0] == 3'h2
		|=> st_q.prio_low[2] == $past(AVS_WRITEDATA_I[3]))
		else $error("single-bit write missed its bit");

	// mode controls; a bus write may still land while the core sleeps
	chk_run_ports: assert property (
		st_q.state == LPS_RUN |-> CORE_CLK_EN_O && !PORT_HOLD_O && !PORT0_FLOAT_O && !PORT2_ADDR_O)
		else $error("run state port controls wrong");

	chk_run_strobes: assert property (
		st_d.state == LPS_RUN
		|=> ALE_O == $past(CORE_ALE_I) && PROGRAM_STORE_STROBE_O == $past(CORE_PROG_STROBE_I))
		else $error("strobes not passed through in run");

	chk_idle_stay: assert property (
		st_q.state == LPS_IDLE && !pick_n[5]
		|=> st_q.state == LPS_IDLE && !CORE_CLK_EN_O && PERIPH_CLK_EN_O && OSC_EN_O)
		else $error("idle left without interrupt");

	chk_idle_float: assert property (
		st_q.state == LPS_IDLE |-> PORT0_FLOAT_O && PERIPH_CLK_EN_O && OSC_EN_O)
		else $error("idle port or clock controls wrong");

	chk_pdown_entry: assert property (
		st_q.state == LPS_RUN && st_q.powerdown_request_bit && INSTR_DONE_I
		|=> st_q.state == LPS_PDOWN && !OSC_EN_O && !CORE_CLK_EN_O && !PERIPH_CLK_EN_O)
		else $error("power-down not entered after instruction");

	chk_pdown_float: assert property (
		st_q.state == LPS_PDOWN |-> PORT_HOLD_O && PORT0_FLOAT_O && !CORE_CLK_EN_O)
		else $error("power-down port controls wrong");

	chk_pdown_stay: assert property (
		st_q.state == LPS_PDOWN && !(|pins_low) |=> st_q.state == LPS_PDOWN && !OSC_EN_O)
		else $error("power-down left without enabled pin");

	chk_pdown_keep: assert property (
		st_q.state == LPS_PDOWN && !bus_commit |=> $stable(st_q.prio_high) && $stable(st_q.prio_low))
		else $error("registers changed in power-down");

	// wake path: oscillator back, core still held
	chk_wake_strobes: assert property (
		st_q.state == LPS_WAKE |-> OSC_EN_O && !ALE_O && !PROGRAM_STORE_STROBE_O && PORT_HOLD_O)
		else $error("wake state controls wrong");

	chk_wake_source: assert property (
		st_q.state == LPS_WAKE && |pins_rel
		|=> IRQ_VALID_O && (IRQ_SRC_O == 3'(LPIRQ_SRC_EXT0) || IRQ_SRC_O == 3'(LPIRQ_SRC_EXT1)))
		else $error("wake exit names a non-pin source");

	chk_wake_pulse: assert property (
		WAKE_VECTOR_O |-> st_q.state == LPS_RUN && IRQ_VALID_O ##1 !WAKE_VECTOR_O)
		else $error("wake pulse malformed");

endmodule

// file: verification/lpirq_core_model.sv
// behavioural processor core and external interrupt pins facing the block
`timescale 1ns/1ps
module lpirq_core_model (
	// clock and gating from the block
	input  wire logic       clk_i,
	input  wire logic       core_clk_en_i,
	// commands from the bench
	input  wire logic       step_i,
	input  wire logic       pin_a_low_i,
	input  wire logic       pin_b_low_i,
	input  wire logic [4:0] req_i,
	// core side of the block
	output logic            instr_done_o = 1'b0,
	output logic            ale_o = 1'b0,
	output logic            pstrobe_o = 1'b0,
	output logic      [4:0] irq_req_o = 5'h00,
	output logic            ext_a_n_o = 1'b1,
	output logic            ext_b_n_o = 1'b1
);
	always_ff @(posedge clk_i) begin
		// a gated core makes no progress, so steps are lost
		instr_done_o <= step_i && core_clk_en_i;
		if (core_clk_en_i) begin
			ale_o     <= ~ale_o;
			pstrobe_o <= ale_o;
		end
		irq_req_o <= req_i;
		// pins held low by the bench until the clock has settled
		ext_a_n_o <= ~pin_a_low_i;
		ext_b_n_o <= ~pin_b_low_i;
	end
endmodule

// file: verification/tb_low_power_mode_and_irq_priority.sv
// self-checking bench for the low-power and interrupt-priority block
`timescale 1ns/1ps
module tb_low_power_mode_and_irq_priority
	import lpirq_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, step = 1'b0, pa = 1'b0, pb = 1'b0, gen = 1'b1;
	logic [9:0]  adr = 10'h000;
	logic [31:0] wd = 32'h0, rdat, rv;
	logic [4:0]  req = 5'h00, en = 5'h1F, irq_r;
	logic        wt, done, ale_c, pst_c, ea_n, eb_n, cclk, pclk, osc, ale, pss, hold, p0f, p2a, iv, wv;
	logic [2:0]  isrc;
	logic [1:0]  ilvl;
	int          mismatches = 0, num_checks = 0;

	initial forever #12.5 clk = ~clk;

	lpirq_core_model i_lpirq_core_model (.clk_i(clk), .core_clk_en_i(cclk), .step_i(step), .pin_a_low_i(pa),
		.pin_b_low_i(pb), .req_i(req), .instr_done_o(done), .ale_o(ale_c), .pstrobe_o(pst_c),
		.irq_req_o(irq_r), .ext_a_n_o(ea_n), .ext_b_n_o(eb_n));

	lpirq_top i_lpirq_top (.MCLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt),
		.INSTR_DONE_I(done), .CORE_ALE_I(ale_c), .CORE_PROG_STROBE_I(pst_c), .IRQ_REQ_I(irq_r), .IRQ_EN_I(en),
		.IRQ_GLOBAL_EN_I(gen), .EXT_IRQ_PIN_A_N_I(ea_n), .EXT_IRQ_PIN_B_N_I(eb_n), .CORE_CLK_EN_O(cclk),
		.PERIPH_CLK_EN_O(pclk), .OSC_EN_O(osc), .ALE_O(ale), .PROGRAM_STORE_STROBE_O(pss), .PORT_HOLD_O(hold),
		.PORT0_FLOAT_O(p0f), .PORT2_ADDR_O(p2a), .IRQ_VALID_O(iv), .IRQ_SRC_O(isrc), .IRQ_LEVEL_O(ilvl),
		.WAKE_VECTOR_O(wv));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 20);
		rv = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			finish_test;
		end
	endtask

	task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(rv, e);
	endtask

	// 0 core clock, 1 oscillator, 2 wake pulse
	task automatic wait_on(input int s, input logic v);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (((s == 0) ? cclk : (s == 1) ? osc : wv) === v)
				break;
		end
		if (n == 200) begin
			mismatches++;
			finish_test;
		end
	endtask

	task automatic pulse_step;
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
	endtask

	task automatic t_regs;
		logic [1:0] a0;
		rdchk(10'h2DC, 32'h0);
		rdchk(10'h2E0, 32'h0);
		rdchk(10'h21C, 32'h0);
		bus(1'b1, 10'h2E0, 8'h1F);
		rdchk(10'h2E0, 32'h1F);
		bus(1'b1, 10'h304, 8'h02);
		rdchk(10'h2E0, 32'h1B);
		bus(1'b1, 10'h2DC, 8'h15);
		rdchk(10'h2DC, 32'h15);
		rdchk(10'h3FC, 32'h0);
		bus(1'b1, 10'h21C, 8'h0C);
		rdchk(10'h21C, 32'h0C);
		// in run the strobes follow the core one cycle late
		@(posedge clk);
		a0 = {ale_c, pst_c};
		@(posedge clk);
		chk({ale, pss}, a0);
	endtask

	task automatic t_prio;
		logic [4:0] h[4] = '{5'h00, 5'h00, 5'h08, 5'h0C};
		logic [4:0] l[4] = '{5'h00, 5'h10, 5'h10, 5'h0C};
		logic [2:0] s[4] = '{3'h0, 3'h4, 3'h3, 3'h2};
		logic [1:0] v[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
		req <= 5'h1F;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 10'h2DC, {3'h0, h[i]});
			bus(1'b1, 10'h2E0, {3'h0, l[i]});
			repeat (3) @(posedge clk);
			chk({iv, isrc, ilvl}, {1'b1, s[i], v[i]});
		end
		rdchk(10'h300, 32'hE8);
		gen <= 1'b0;
		repeat (3) @(posedge clk);
		chk(iv, 1'b0);
		gen <= 1'b1;
		req <= 5'h00;
	endtask

	task automatic t_idle;
		bus(1'b1, 10'h21C, 8'h01);
		pulse_step;
		wait_on(0, 1'b0);
		chk({ale, pss, p2a, p0f, hold, pclk, osc}, 7'h7F);
		rdchk(10'h2E0, 32'h0C);
		rdchk(10'h300, 32'h01);
		req <= 5'h02;
		wait_on(2, 1'b1);
		chk(isrc, 3'h1);
		req <= 5'h00;
		rdchk(10'h21C, 32'h0);
		chk(cclk, 1'b1);
	endtask

	task automatic t_pdown;
		bus(1'b1, 10'h2DC, 8'h04);
		bus(1'b1, 10'h2E0, 8'h00);
		bus(1'b1, 10'h21C, 8'h03);
		pulse_step;
		wait_on(1, 1'b0);
		chk({cclk, pclk, ale, pss, p2a, p0f, hold}, 7'h03);
		req <= 5'h02;
		repeat (8) @(posedge clk);
		chk(osc, 1'b0);
		req <= 5'h00;
		en <= 5'h1A;
		pa <= 1'b1;
		repeat (4) @(posedge clk);
		chk(osc, 1'b0);
		en <= 5'h1F;
		@(posedge clk);
		pb <= 1'b1;
		wait_on(1, 1'b1);
		rdchk(10'h300, 32'h02);
		repeat (10) @(posedge clk);
		chk(cclk, 1'b0);
		pa <= 1'b0;
		wait_on(2, 1'b1);
		chk(isrc, 3'h2);
		pb <= 1'b0;
		rdchk(10'h21C, 32'h0);
		rdchk(10'h2DC, 32'h04);
	endtask

	task automatic t_reset;
		bus(1'b1, 10'h21C, 8'h02);
		pulse_step;
		wait_on(1, 1'b0);
		rst <= 1'b1;
		repeat (24) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({osc, cclk}, 2'h3);
		rdchk(10'h2DC, 32'h0);
		rdchk(10'h21C, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_prio;
		t_idle;
		t_pdown;
		t_reset;
		finish_test;
	end
endmodule
